// ===== src/tlx_consts.vh
// tlx_consts.vh: opcode patterns, register offsets and field positions
// assumes: included by the tlx design files by bare name
`ifndef TLX_CONSTS_VH
`define TLX_CONSTS_VH

// file register offsets
`define TLX_ADDR_IND0      8'h00
`define TLX_ADDR_PTR0      8'h01
`define TLX_ADDR_ALU_STAT  8'h04
`define TLX_ADDR_IND1      8'h08
`define TLX_ADDR_PTR1      8'h09
`define TLX_ADDR_TPTR_LO   8'h0d
`define TLX_ADDR_TPTR_HI   8'h0e
`define TLX_ADDR_WREG      8'h0f

// reset values
`define TLX_RST_BYTE       8'h00
`define TLX_RST_WORD       16'h0000

// opcode patterns, compared against opcode bits 15:8 under a mask (TSTZ and XORL compared whole, unmasked)
`define TLX_OP_TABLE_LATCH_READ_OP_MASK   8'hfc
`define TLX_OP_TABLE_LATCH_READ_OP_VAL    8'ha0
`define TLX_OP_TABLE_LATCH_WRITE_OP_MASK   8'hfc
`define TLX_OP_TABLE_LATCH_WRITE_OP_VAL    8'ha4
`define TLX_OP_TBRD_MASK   8'hfc
`define TLX_OP_TBRD_VAL    8'ha8
`define TLX_OP_TBWT_MASK   8'hfc
`define TLX_OP_TBWT_VAL    8'hac
`define TLX_OP_TSTZ_VAL    8'h33
`define TLX_OP_XORL_VAL    8'hb4
`define TLX_OP_XORF_MASK   8'hfe
`define TLX_OP_XORF_VAL    8'h0c
`define TLX_OP_MVFP_MASK   8'he0
`define TLX_OP_MVFP_VAL    8'h60
`define TLX_OP_MVPF_MASK   8'he0
`define TLX_OP_MVPF_VAL    8'h40

// opcode field positions
`define TLX_BIT_T          9
`define TLX_BIT_I          8
`define TLX_BIT_D          8

// status register fields
`define TLX_STAT_Z         2
`define TLX_STAT_P0_HI     5
`define TLX_STAT_P0_LO     4
`define TLX_STAT_P1_HI     7
`define TLX_STAT_P1_LO     6

// pointer step encoding (two bits per pointer)
`define TLX_STEP_DEC       2'b00
`define TLX_STEP_INC       2'b01

`endif

// ===== src/tlx_core.v
// tlx_core.v: decode and execution of table latch, skip-on-zero, xor and
// indirect move instructions, plus the register port for software
// assumes: one instruction per enabled cycle on instr/instr_valid; program
// memory answers table reads combinationally on pmem_rdata
`timescale 1ns/1ps
`include "tlx_consts.vh"

// Notes on behaviour
// - table latch read copies low or high latch byte into file f
// - table latch write loads file f into low or high latch byte
// - latch instructions touch no flag; x bit ignored by decode
// - test-skip-zero skips next instruction when file f is zero
// - taken skip discards prefetched instruction, runs a nop instead
// - xor literal: w xor k into w, zero flag updated
// - xor file: w xor f into w or f by d, zero flag updated
// - addresses 00h and 08h redirect through pointer zero and one
// - indirect read landing on 00h or 08h returns zero
// - indirect write landing on 00h or 08h does nothing
// - moves between 00h and 08h finish in one cycle either way
// - pointers step after each indirect access per status bits 7:4
// - files 0dh and 0eh form the sixteen-bit table pointer
// - table read and write address program memory with the table pointer
// - table latch is a hidden sixteen-bit register, reached by table ops
// - table write loads latch byte, writes memory, optional pointer increment
module tlx_core (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        ce,
    input  wire [15:0] instr,
    input  wire        instr_valid,
    output wire        skip_next,
    output reg  [15:0] pmem_addr,
    output reg  [15:0] pmem_wdata,
    output reg         pmem_we,
    input  wire [15:0] pmem_rdata,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output wire [7:0]  wreg_out,
    output wire [15:0] table_latch_out
);

////////////////////////////////////////////////////////////////////////////////
// state

reg  [7:0]  data_pointer_zero_q;
reg  [7:0]  data_pointer_one_q;
reg  [7:0]  alu_status_q;
reg  [7:0]  table_pointer_low_q;
reg  [7:0]  table_pointer_high_q;
reg  [7:0]  wreg_q;
reg  [7:0]  table_latch_low_q;
reg  [7:0]  table_latch_high_q;
reg         skip_q;

function match;
    input [7:0] hi;
    input [7:0] mask;
    input [7:0] val;
    begin
        match = ((hi & mask) == val);
    end
endfunction

function is_ind;
    input [7:0] a;
    begin
        is_ind = (a == `TLX_ADDR_IND0) || (a == `TLX_ADDR_IND1);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// decode

wire        go   = ce && instr_valid && !skip_q;
wire [7:0]  ophi = instr[15:8];
wire [7:0]  fadr = instr[7:0];
wire        tsel = instr[`TLX_BIT_T];

wire op_table_latch_read_op = go && match(ophi, `TLX_OP_TABLE_LATCH_READ_OP_MASK, `TLX_OP_TABLE_LATCH_READ_OP_VAL);
wire op_table_latch_write_op = go && match(ophi, `TLX_OP_TABLE_LATCH_WRITE_OP_MASK, `TLX_OP_TABLE_LATCH_WRITE_OP_VAL);
wire op_tbrd = go && match(ophi, `TLX_OP_TBRD_MASK, `TLX_OP_TBRD_VAL);
wire op_tbwt = go && match(ophi, `TLX_OP_TBWT_MASK, `TLX_OP_TBWT_VAL);
wire op_tstz = go && (ophi == `TLX_OP_TSTZ_VAL);
wire op_xorl = go && (ophi == `TLX_OP_XORL_VAL);
wire op_xorf = go && match(ophi, `TLX_OP_XORF_MASK, `TLX_OP_XORF_VAL);
wire op_mvfp = go && match(ophi, `TLX_OP_MVFP_MASK, `TLX_OP_MVFP_VAL);
wire op_mvpf = go && match(ophi, `TLX_OP_MVPF_MASK, `TLX_OP_MVPF_VAL);
wire op_move = op_mvfp || op_mvpf;
wire [7:0] padr = {3'b000, instr[12:8]};

// move source/destination: file-to-periph reads f writes p, and the reverse
wire [7:0] src_a = op_mvfp ? fadr : (op_mvpf ? padr : fadr);
wire [7:0] dst_a = op_mvfp ? padr : fadr;

////////////////////////////////////////////////////////////////////////////////
// address resolution

function [7:0] resolve;
    input [7:0] a;
    input [7:0] p0;
    input [7:0] p1;
    begin
        if (a == `TLX_ADDR_IND0)
            resolve = p0;
        else if (a == `TLX_ADDR_IND1)
            resolve = p1;
        else
            resolve = a;
    end
endfunction

wire [7:0] src_phys = resolve(src_a, data_pointer_zero_q, data_pointer_one_q);
wire [7:0] dst_phys = resolve(dst_a, data_pointer_zero_q, data_pointer_one_q);
wire       src_ind  = is_ind(src_a);
wire       dst_ind  = is_ind(dst_a);

wire [7:0] ram_rdata;
reg  [7:0] src_val;

// file read of a resolved address
always @* begin
    if (src_ind && is_ind(src_phys))
        src_val = 8'h00;
    else begin
        case (src_phys)
            `TLX_ADDR_PTR0:     src_val = data_pointer_zero_q;
            `TLX_ADDR_PTR1:     src_val = data_pointer_one_q;
            `TLX_ADDR_ALU_STAT: src_val = alu_status_q;
            `TLX_ADDR_TPTR_LO:  src_val = table_pointer_low_q;
            `TLX_ADDR_TPTR_HI:  src_val = table_pointer_high_q;
            `TLX_ADDR_WREG:     src_val = wreg_q;
            default:            src_val = ram_rdata;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// execute

wire [7:0] xor_f   = wreg_q ^ src_val;
wire [7:0] xor_k   = wreg_q ^ fadr;
wire       xor_dst = instr[`TLX_BIT_D];

reg        fw_en;
reg  [7:0] fw_val;

always @* begin
    fw_en  = 1'b0;
    fw_val = src_val;
    if (op_table_latch_read_op) begin
        fw_en  = 1'b1;
        fw_val = tsel ? table_latch_high_q : table_latch_low_q;
    end else if (op_tbrd) begin
        fw_en  = 1'b1;
        fw_val = tsel ? table_latch_high_q : table_latch_low_q;
    end else if (op_xorf && xor_dst) begin
        fw_en  = 1'b1;
        fw_val = xor_f;
    end else if (op_move) begin
        fw_en  = 1'b1;
        fw_val = src_val;
    end
end

// indirect write landing on an indirect address is dropped
wire       fw_ok   = fw_en && !(dst_ind && is_ind(dst_phys));
wire       ram_sel = !(dst_phys == `TLX_ADDR_PTR0 || dst_phys == `TLX_ADDR_PTR1 ||
                       dst_phys == `TLX_ADDR_ALU_STAT || dst_phys == `TLX_ADDR_TPTR_LO ||
                       dst_phys == `TLX_ADDR_TPTR_HI || dst_phys == `TLX_ADDR_WREG);
wire       sw_ram  = reg_wr && !go && !is_ind(reg_addr);
wire       ram_we  = (fw_ok && ram_sel) || (!fw_ok && sw_ram);
wire [7:0] ram_wa  = fw_ok ? dst_phys : reg_addr;
wire [7:0] ram_wd  = fw_ok ? fw_val : reg_wdata;

tlx_data_ram u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (ram_we),
    .waddr (ram_wa),
    .wdata (ram_wd),
    .raddr (go ? src_phys : reg_addr),
    .rdata (ram_rdata)
);

// pointer stepping; a source or destination access, or both at once, steps that pointer once
// a literal or undecoded opcode has no file operand and never steps a pointer
wire src_use = op_table_latch_write_op || op_tbwt || op_tstz || op_xorf || op_move;
wire acc0    = (src_use && src_a == `TLX_ADDR_IND0) || (fw_en && dst_a == `TLX_ADDR_IND0);
wire acc1    = (src_use && src_a == `TLX_ADDR_IND1) || (fw_en && dst_a == `TLX_ADDR_IND1);
wire [7:0] p0_next;
wire [7:0] p1_next;

tlx_ptr_step u_step0 (
    .ptr      (data_pointer_zero_q),
    .step     (alu_status_q[`TLX_STAT_P0_HI:`TLX_STAT_P0_LO]),
    .access   (acc0),
    .ptr_next (p0_next)
);

tlx_ptr_step u_step1 (
    .ptr      (data_pointer_one_q),
    .step     (alu_status_q[`TLX_STAT_P1_HI:`TLX_STAT_P1_LO]),
    .access   (acc1),
    .ptr_next (p1_next)
);

wire [15:0] table_pointer = {table_pointer_high_q, table_pointer_low_q};
wire [15:0] tlat_wr       = tsel ? {src_val, table_latch_low_q} : {table_latch_high_q, src_val};

assign skip_next       = skip_q;
assign wreg_out        = wreg_q;
assign table_latch_out = {table_latch_high_q, table_latch_low_q};

////////////////////////////////////////////////////////////////////////////////
// registers

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        data_pointer_zero_q  <= `TLX_RST_BYTE;
        data_pointer_one_q   <= `TLX_RST_BYTE;
        alu_status_q         <= `TLX_RST_BYTE;
        table_pointer_low_q  <= `TLX_RST_BYTE;
        table_pointer_high_q <= `TLX_RST_BYTE;
        wreg_q               <= `TLX_RST_BYTE;
        table_latch_low_q    <= `TLX_RST_BYTE;
        table_latch_high_q   <= `TLX_RST_BYTE;
        skip_q               <= 1'b0;
        pmem_addr            <= `TLX_RST_WORD;
        pmem_wdata           <= `TLX_RST_WORD;
        pmem_we              <= 1'b0;
        reg_rdata            <= `TLX_RST_BYTE;
    end else if (ce) begin
        pmem_we   <= 1'b0;
        reg_rdata <= `TLX_RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `TLX_ADDR_PTR0:     reg_rdata <= data_pointer_zero_q;
                `TLX_ADDR_PTR1:     reg_rdata <= data_pointer_one_q;
                `TLX_ADDR_ALU_STAT: reg_rdata <= alu_status_q;
                `TLX_ADDR_TPTR_LO:  reg_rdata <= table_pointer_low_q;
                `TLX_ADDR_TPTR_HI:  reg_rdata <= table_pointer_high_q;
                `TLX_ADDR_WREG:     reg_rdata <= wreg_q;
                `TLX_ADDR_IND0:     reg_rdata <= `TLX_RST_BYTE;
                `TLX_ADDR_IND1:     reg_rdata <= `TLX_RST_BYTE;
                default:            reg_rdata <= go ? `TLX_RST_BYTE : ram_rdata;
            endcase
        end
        if (reg_wr && !go) begin
            case (reg_addr)
                `TLX_ADDR_PTR0:     data_pointer_zero_q  <= reg_wdata;
                `TLX_ADDR_PTR1:     data_pointer_one_q   <= reg_wdata;
                `TLX_ADDR_ALU_STAT: alu_status_q         <= reg_wdata;
                `TLX_ADDR_TPTR_LO:  table_pointer_low_q  <= reg_wdata;
                `TLX_ADDR_TPTR_HI:  table_pointer_high_q <= reg_wdata;
                `TLX_ADDR_WREG:     wreg_q               <= reg_wdata;
                default:            wreg_q               <= wreg_q;
            endcase
        end
        if (instr_valid) begin
            skip_q <= op_tstz && (src_val == 8'h00);
        end
        if (go) begin
            data_pointer_zero_q <= p0_next;
            data_pointer_one_q  <= p1_next;
            if (fw_ok && dst_phys == `TLX_ADDR_PTR0)
                data_pointer_zero_q <= fw_val;
            if (fw_ok && dst_phys == `TLX_ADDR_PTR1)
                data_pointer_one_q <= fw_val;
            if (fw_ok && dst_phys == `TLX_ADDR_ALU_STAT)
                alu_status_q <= fw_val;
            if (fw_ok && dst_phys == `TLX_ADDR_TPTR_LO)
                table_pointer_low_q <= fw_val;
            if (fw_ok && dst_phys == `TLX_ADDR_TPTR_HI)
                table_pointer_high_q <= fw_val;
            if (fw_ok && dst_phys == `TLX_ADDR_WREG)
                wreg_q <= fw_val;
            if (op_xorl) begin
                wreg_q                      <= xor_k;
                alu_status_q[`TLX_STAT_Z]   <= (xor_k == 8'h00);
            end
            if (op_xorf) begin
                if (!xor_dst)
                    wreg_q <= xor_f;
                alu_status_q[`TLX_STAT_Z] <= (xor_f == 8'h00);
            end
            if (op_table_latch_write_op) begin
                table_latch_high_q <= tlat_wr[15:8];
                table_latch_low_q  <= tlat_wr[7:0];
            end
            if (op_tbrd) begin
                pmem_addr          <= table_pointer;
                table_latch_high_q <= pmem_rdata[15:8];
                table_latch_low_q  <= pmem_rdata[7:0];
                if (instr[`TLX_BIT_I])
                    {table_pointer_high_q, table_pointer_low_q} <= table_pointer + 16'h0001;
            end
            if (op_tbwt) begin
                table_latch_high_q <= tlat_wr[15:8];
                table_latch_low_q  <= tlat_wr[7:0];
                pmem_addr          <= table_pointer;
                pmem_wdata         <= tlat_wr;
                pmem_we            <= 1'b1;
                if (instr[`TLX_BIT_I])
                    {table_pointer_high_q, table_pointer_low_q} <= table_pointer + 16'h0001;
            end
        end
    end
end

endmodule // tlx_core

// ===== src/tlx_data_ram.v
// tlx_data_ram.v: general data memory, 256 bytes, one read and one write port
// assumes: read is combinational, write is clocked under the clock enable
`timescale 1ns/1ps
`include "tlx_consts.vh"

module tlx_data_ram (
    input  wire       clk,
    input  wire       ce,
    input  wire       we,
    input  wire [7:0] waddr,
    input  wire [7:0] wdata,
    input  wire [7:0] raddr,
    output wire [7:0] rdata
);

reg [7:0] mem [0:255];

assign rdata = mem[raddr];

always @(posedge clk) begin
    if (ce && we) begin
        mem[waddr] <= wdata;
    end
end

endmodule // tlx_data_ram

// ===== src/tlx_ptr_step.v
// tlx_ptr_step.v: next value of one data pointer after an indirect access
// assumes: step code comes from the status register, access is a one-cycle qualifier
`timescale 1ns/1ps
`include "tlx_consts.vh"

module tlx_ptr_step (
    input  wire [7:0] ptr,
    input  wire [1:0] step,
    input  wire       access,
    output reg  [7:0] ptr_next
);

always @* begin
    ptr_next = ptr;
    if (access) begin
        case (step)
            `TLX_STEP_INC: ptr_next = ptr + 8'h01;
            `TLX_STEP_DEC: ptr_next = ptr - 8'h01;
            default:       ptr_next = ptr;
        endcase
    end
end

endmodule // tlx_ptr_step

// ===== testbench/tb_tlx_core.sv
// tb_tlx_core.sv: self-checking bench driving tlx_core register and instruction ports
// assumes: tlx_core and tlx_core_checker compiled first
`timescale 1ns/1ps
module tb_tlx_core;
    reg         clk;
    reg         reset_n;
    reg         ce;
    reg  [15:0] instr;
    reg         instr_valid;
    reg  [7:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire        skip_next;
    wire [15:0] pmem_addr;
    wire [15:0] pmem_wdata;
    wire        pmem_we;
    wire [7:0]  reg_rdata;
    wire [7:0]  wreg_out;
    wire [15:0] table_latch_out;
    integer     n_fail;
    integer     checked;
    integer     p;
    integer     s;
    reg  [7:0]  v;
    tlx_core i_dut (
        .clk(clk), .reset_n(reset_n), .ce(ce), .instr(instr),
        .instr_valid(instr_valid), .skip_next(skip_next), .pmem_addr(pmem_addr),
        .pmem_wdata(pmem_wdata), .pmem_we(pmem_we), .pmem_rdata(16'hbeef),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wreg_out(wreg_out), .table_latch_out(table_latch_out)
    );
    ////////////////////////////////////////////////////////////////////////////
    task chk(input [15:0] g, input [15:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t ns: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge clk);
            reg_wr    <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge clk);
            reg_rd   <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        begin
            rd(a, v);
            chk(v, e);
        end
    endtask
    task ex(input [15:0] i);
        begin
            @(posedge clk);
            instr       <= i;
            instr_valid <= 1'b1;
            @(posedge clk);
            instr_valid <= 1'b0;
            #1;
        end
    endtask
    task sk(input [7:0] f, input e);
        begin
            @(posedge clk);
            instr       <= {8'h33, f};
            instr_valid <= 1'b1;
            @(posedge clk);
            instr       <= 16'hb401;
            #1 chk(skip_next, e);
            @(posedge clk);
            instr_valid <= 1'b0;
            #1;
        end
    endtask
    task print_verdict;
        begin
            if (n_fail == 0 && checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        n_fail = n_fail + 1;
        print_verdict;
    end
    initial begin
        n_fail = 0;
        checked = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        instr = 16'h0000;
        instr_valid = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        chk(table_latch_out, 16'h0000);
        rc(8'h0d, 8'h00);
        rc(8'h0e, 8'h00);
        rc(8'h01, 8'h00);
        rc(8'h09, 8'h00);
        wr(8'h0f, 8'h55);
        ex(16'hb4aa);
        chk(wreg_out, 8'hff);
        ex(16'hb4ff);
        rd(8'h04, v);
        chk(v & 8'h04, 8'h04);
        wr(8'h20, 8'h0f);
        wr(8'h0f, 8'hf0);
        ex(16'h0d20);
        chk(wreg_out, 8'hf0);
        rc(8'h20, 8'hff);
        ex(16'h0c20);
        chk(wreg_out, 8'h0f);
        ex(16'hb40f);
        wr(8'h30, 8'h12);
        wr(8'h31, 8'h34);
        wr(8'h32, 8'h99);
        ex(16'ha430);
        ex(16'ha631);
        ex(16'ha532);
        chk(table_latch_out, 16'h3499);
        rd(8'h04, v);
        chk(v & 8'h04, 8'h04);
        ex(16'ha040);
        ex(16'ha341);
        rc(8'h40, 8'h99);
        rc(8'h41, 8'h34);
        chk(table_latch_out, 16'h3499);
        wr(8'h50, 8'h00);
        wr(8'h51, 8'h07);
        sk(8'h50, 1'b1);
        chk(wreg_out, 8'h00);
        sk(8'h51, 1'b0);
        chk(wreg_out, 8'h01);
        wr(8'h60, 8'ha5);
        for (p = 0; p < 2; p = p + 1) begin
            for (s = 0; s < 3; s = s + 1) begin
                wr(8'h04, p ? {s[1:0], 6'h30} : {2'b11, s[1:0], 4'h0});
                wr(p ? 8'h09 : 8'h01, 8'h60);
                ex(p ? 16'h0c08 : 16'h0c00);
                chk(wreg_out, (p[0] ^ s[0]) ? 8'h01 : 8'ha4);
                rc(p ? 8'h09 : 8'h01, s == 0 ? 8'h5f : s == 1 ? 8'h61 : 8'h60);
            end
        end
        chk(wreg_out, 8'h01);
        wr(8'h04, 8'hf0);
        wr(8'h01, 8'h08);
        ex(16'h0c00);
        chk(wreg_out, 8'h01);
        wr(8'h09, 8'h00);
        ex(16'ha008);
        rc(8'h01, 8'h08);
        ex(16'h0c08);
        chk(wreg_out, 8'h01);
        @(posedge clk);
        ce <= 1'b0;
        ex(16'hb4ff);
        chk(wreg_out, 8'h01);
        @(posedge clk);
        ce <= 1'b1;
        wr(8'h01, 8'h80);
        wr(8'h09, 8'h81);
        wr(8'h81, 8'h3c);
        ex(16'h6008);
        rc(8'h80, 8'h3c);
        wr(8'h80, 8'hc3);
        ex(16'h4008);
        rc(8'h81, 8'hc3);
        wr(8'h0d, 8'h34);
        wr(8'h0e, 8'h12);
        ex(16'had30);
        chk(pmem_we, 1'b1);
        chk(pmem_addr, 16'h1234);
        chk(pmem_wdata, 16'h3412);
        rc(8'h0d, 8'h35);
        ex(16'ha930);
        chk(table_latch_out, 16'hbeef);
        chk(pmem_addr, 16'h1235);
        rc(8'h0d, 8'h36);
        print_verdict;
    end
endmodule // tb_tlx_core

bind tlx_core tlx_core_checker i_chk (
    .clk(clk), .reset_n(reset_n), .ce(ce), .instr(instr), .instr_valid(instr_valid),
    .skip_next(skip_next), .pmem_we(pmem_we), .pmem_wdata(pmem_wdata),
    .wreg_out(wreg_out), .table_latch_out(table_latch_out)
);

// ===== testbench/tlx_core_checker.sv
// tlx_core_checker.sv: port-level assertions for tlx_core
// assumes: bound to tlx_core from the bench top, single clock domain
`timescale 1ns/1ps
module tlx_core_checker (
    input wire        clk,
    input wire        reset_n,
    input wire        ce,
    input wire [15:0] instr,
    input wire        instr_valid,
    input wire        skip_next,
    input wire        pmem_we,
    input wire [15:0] pmem_wdata,
    input wire [7:0]  wreg_out,
    input wire [15:0] table_latch_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire       run = ce && instr_valid && !skip_next;
    wire [7:0] hi  = instr[15:8];
    ////////////////////////////////////////////////////////////////////////////
    a_skip_cause: assert property ($rose(skip_next) |-> $past(run && hi == 8'h33))
        else $error("skip without a zero test");
    a_skip_single: assert property (skip_next && ce && instr_valid |=> !skip_next)
        else $error("skip lasted two cycles");
    a_table_latch_read_op_latch_kept: assert property (run && hi[7:2] == 6'b101000 |=>
        $stable(table_latch_out)) else $error("latch read changed latch");
    a_table_latch_write_op_lo_only: assert property (run && hi[7:1] == 7'b1010010 |=>
        table_latch_out[15:8] == $past(table_latch_out[15:8])) else $error("high byte hit");
    a_table_latch_write_op_hi_only: assert property (run && hi[7:1] == 7'b1010011 |=>
        table_latch_out[7:0] == $past(table_latch_out[7:0])) else $error("low byte hit");
    a_latch_w_kept: assert property (run && hi[7:3] == 5'b10100 && instr[7:0] > 8'h0f
        |=> $stable(wreg_out)) else $error("latch op changed w");
    a_xorl_result: assert property (run && hi == 8'hb4 |=>
        wreg_out == $past(wreg_out ^ instr[7:0])) else $error("xor literal wrong");
    a_xorf_to_file: assert property (run && hi == 8'h0d && instr[7:0] > 8'h0f
        |=> $stable(wreg_out)) else $error("xor to file changed w");
    a_tbwt_pulse: assert property (run && hi[7:2] == 6'b101011 |=>
        pmem_we && pmem_wdata == table_latch_out) else $error("table write lost");
    a_we_cause: assert property (pmem_we |-> $past(run && hi[7:2] == 6'b101011))
        else $error("stray program write");
    c_skip: cover property (skip_next);
    c_pwrite: cover property (pmem_we);
    c_xorl: cover property (run && hi == 8'hb4);
endmodule // tlx_core_checker
